// ### design/lmp_dimming_core.sv
// Twelve-channel PWM dimming core driving LED bypass switches.
// Assumes one 40 MHz core clock, synchronous inputs, and a host that strobes writes.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Separate on and off count per channel
// - Ten-bit counter compared against all counts
// - On-count match opens bypass, LED lit
// - Off-count match closes bypass, LED dark
// - Counter runs 0 to 1023, then wraps
// - Period is 1024 divided clock ticks
// - Compare enable gates both match results
// - Power-of-two prescaler then decimal divider
// - Divider resets to divide by sixteen
// - Counter clears to zero at reset
// - Master select drives sync line, default input
// - Master emits half-period high pulse at wrap
// - Follower rising sync edge clears counter, divider
// - Broadcast sync command clears counter, divider
// - Command alignment within sixteen clock cycles
// - Equal counts: off match wins
// - New counts staged until opposite match
module lmp_dimming_core (
    input  wire logic                             core_clk_i,
    input  wire logic                             rstn_i,
    input  wire logic                             cnt_wr_i,
    input  wire logic [lmp_pkg::CH_IDX_W-1:0]     cnt_wr_chan_i,
    input  wire logic                             cnt_wr_sel_off_i,
    input  wire logic [lmp_pkg::CNT_W-1:0]        cnt_wr_data_i,
    input  wire logic [lmp_pkg::NUM_CH-1:0]       channel_compare_enable_i,
    input  wire logic                             cfg_wr_i,
    input  wire logic [lmp_pkg::DIV_W-1:0]        pwm_clock_divider_setting_i,
    input  wire logic                             sync_master_select_i,
    input  wire logic                             sync_cmd_i,
    input  wire logic                             sync_i,
    output logic                                  sync_o,
    output logic                                  sync_oe_o,
    output logic      [lmp_pkg::NUM_CH-1:0]       bypass_on_o,
    output logic      [lmp_pkg::CNT_W-1:0]        pwm_period_counter_o,
    output logic      [lmp_pkg::DIV_W-1:0]        divider_setting_o,
    output logic                                  sync_master_o
);

    // Configuration registers
    logic [lmp_pkg::DIV_W-1:0]        div_q;
    logic [lmp_pkg::DIV_W-1:0]        div_d;
    logic                             master_q;
    logic                             master_d;

    // Divider and period counter
    logic [lmp_pkg::PRE_W-1:0]        pre_cnt_q;
    logic [lmp_pkg::PRE_W-1:0]        pre_cnt_d;
    logic [lmp_pkg::DIV_DEC_W-1:0]    dec_cnt_q;
    logic [lmp_pkg::DIV_DEC_W-1:0]    dec_cnt_d;
    logic [lmp_pkg::CNT_W-1:0]        cnt_q;
    logic [lmp_pkg::CNT_W-1:0]        cnt_d;

    // Sync line handling
    logic                             sync_meta_q;
    logic                             sync_s_q;
    logic                             sync_prev_q;
    logic                             sync_out_q;
    logic                             sync_out_d;

    // Channel outputs and active counts
    logic [lmp_pkg::NUM_CH-1:0]       bypass_q;
    logic [lmp_pkg::NUM_CH-1:0]       bypass_d;
    logic [lmp_pkg::NUM_CH-1:0]       on_hit;
    logic [lmp_pkg::NUM_CH-1:0]       off_hit;
    logic [lmp_pkg::NUM_CH-1:0]       on_act;
    logic [lmp_pkg::NUM_CH-1:0]       off_act;
    logic [lmp_pkg::NUM_CH*lmp_pkg::CNT_W-1:0] act_on;
    logic [lmp_pkg::NUM_CH*lmp_pkg::CNT_W-1:0] act_off;

    // Divider field decode
    wire  [lmp_pkg::DIV_EXP_W-1:0]    div_exp   = div_q[lmp_pkg::DIV_EXP_LSB +: lmp_pkg::DIV_EXP_W];
    wire  [lmp_pkg::DIV_DEC_W-1:0]    div_dec   = div_q[lmp_pkg::DIV_DEC_LSB +: lmp_pkg::DIV_DEC_W];
    wire  [7:0]                       pre_span  = 8'h01 << div_exp;
    wire  [lmp_pkg::PRE_W-1:0]        pre_last  = 7'(pre_span - 8'h01);
    wire                              pre_wrap  = pre_cnt_q >= pre_last;
    wire                              dec_wrap  = dec_cnt_q >= div_dec;
    wire                              tick      = pre_wrap & dec_wrap;
    wire                              at_last   = cnt_q == lmp_pkg::CNT_LAST;
    wire                              at_half   = cnt_q == lmp_pkg::CNT_HALF_LAST;
    wire                              wrap_tick = tick & at_last;
    wire                              half_tick = tick & at_half;
    wire  [lmp_pkg::PRE_W-1:0]        pre_inc   = pre_cnt_q + 7'h01;
    wire  [lmp_pkg::DIV_DEC_W-1:0]    dec_inc   = dec_cnt_q + 5'h01;
    wire  [lmp_pkg::CNT_W-1:0]        cnt_inc   = cnt_q + 10'h001;

    // Phase alignment sources
    wire                              follow_rise = ~master_q & sync_s_q & ~sync_prev_q;
    wire                              align_clr   = sync_cmd_i | follow_rise;

    // Configuration update
    assign div_d    = cfg_wr_i ? pwm_clock_divider_setting_i : div_q;
    assign master_d = cfg_wr_i ? sync_master_select_i : master_q;

    // Prescaler then decimal divider, both cleared by alignment
    assign pre_cnt_d = align_clr ? lmp_pkg::PRE_RESET :
                       pre_wrap  ? lmp_pkg::PRE_RESET :
                       pre_inc;
    assign dec_cnt_d = align_clr ? lmp_pkg::DEC_RESET :
                       !pre_wrap ? dec_cnt_q :
                       dec_wrap  ? lmp_pkg::DEC_RESET :
                       dec_inc;

    // Free-running period counter, natural wrap after 1023
    assign cnt_d = align_clr ? lmp_pkg::CNT_RESET :
                   tick      ? cnt_inc :
                   cnt_q;

    // Master pulse: rises at wrap, falls after half a period
    assign sync_out_d = ~master_q ? 1'b0 :
                        wrap_tick ? 1'b1 :
                        half_tick ? 1'b0 :
                        sync_out_q;

    // Per-channel comparison and switch control
    genvar i;
    generate
        for (i = 0; i < lmp_pkg::NUM_CH; i++) begin : g_cmp
            wire [lmp_pkg::CNT_W-1:0] on_val  = act_on[i*lmp_pkg::CNT_W +: lmp_pkg::CNT_W];
            wire [lmp_pkg::CNT_W-1:0] off_val = act_off[i*lmp_pkg::CNT_W +: lmp_pkg::CNT_W];
            wire                      en      = channel_compare_enable_i[i];

            assign on_hit[i]   = cnt_q == on_val;
            assign off_hit[i]  = cnt_q == off_val;
            assign on_act[i]   = en & on_hit[i];
            assign off_act[i]  = en & off_hit[i];
            assign bypass_d[i] = off_act[i] ? 1'b1 :
                                 on_act[i]  ? 1'b0 :
                                 bypass_q[i];
        end
    endgenerate

    // Staged and active counts per channel
    lmp_count_store u_store (
        .core_clk_i   (core_clk_i),
        .rstn_i       (rstn_i),
        .wr_i         (cnt_wr_i),
        .wr_chan_i    (cnt_wr_chan_i),
        .wr_sel_off_i (cnt_wr_sel_off_i),
        .wr_data_i    (cnt_wr_data_i),
        .on_hit_i     (on_hit),
        .off_hit_i    (off_hit),
        .act_on_o     (act_on),
        .act_off_o    (act_off)
    );

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_q <= lmp_pkg::DIV_RESET;
        end else begin
            div_q <= div_d;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            master_q <= lmp_pkg::SYNC_MASTER_RESET;
        end else begin
            master_q <= master_d;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_cnt_q <= lmp_pkg::PRE_RESET;
            dec_cnt_q <= lmp_pkg::DEC_RESET;
        end else begin
            pre_cnt_q <= pre_cnt_d;
            dec_cnt_q <= dec_cnt_d;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= lmp_pkg::CNT_RESET;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Two-flop synchroniser on the sync input, then edge history
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_meta_q <= 1'b0;
            sync_s_q    <= 1'b0;
            sync_prev_q <= 1'b0;
        end else begin
            sync_meta_q <= sync_i;
            sync_s_q    <= sync_meta_q;
            sync_prev_q <= sync_s_q;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_out_q <= 1'b0;
        end else begin
            sync_out_q <= sync_out_d;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bypass_q <= lmp_pkg::BYPASS_RESET;
        end else begin
            bypass_q <= bypass_d;
        end
    end

    // Sole driver only when master selected
    assign sync_oe_o            = master_q;
    assign sync_o               = sync_out_q;
    assign bypass_on_o          = bypass_q;
    assign pwm_period_counter_o = cnt_q;
    assign divider_setting_o    = div_q;
    assign sync_master_o        = master_q;

endmodule : lmp_dimming_core

`default_nettype wire

// ### shared/lmp_pkg.sv
// Constants for the twelve-channel LED PWM dimming core.
// Assumes a single core clock at 40 MHz; no register bus, all controls are ports.
package lmp_pkg;

    // Channel and counter geometry
    localparam int unsigned NUM_CH         = 12;
    localparam int unsigned CH_IDX_W       = 4;
    localparam int unsigned CNT_W          = 10;
    localparam logic [9:0]  CNT_LAST       = 10'h3FF;
    localparam logic [9:0]  CNT_HALF_LAST  = 10'h1FF;
    localparam logic [9:0]  CNT_RESET      = 10'h000;
    localparam int unsigned PERIOD_TICKS   = 1024;

    // Clock divider setting layout: [2:0] power-of-two exponent, [7:3] decimal count minus one
    localparam int unsigned DIV_W          = 8;
    localparam int unsigned DIV_EXP_LSB    = 0;
    localparam int unsigned DIV_EXP_W      = 3;
    localparam int unsigned DIV_DEC_LSB    = 3;
    localparam int unsigned DIV_DEC_W      = 5;
    localparam int unsigned PRE_W          = 7;
    localparam logic [7:0]  DIV_RESET      = 8'h04;
    localparam logic [6:0]  PRE_RESET      = 7'h00;
    localparam logic [4:0]  DEC_RESET      = 5'h00;

    // Configuration and outputs after reset
    localparam logic        SYNC_MASTER_RESET = 1'b0;
    localparam logic [11:0] BYPASS_RESET      = 12'hFFF;
    localparam logic [9:0]  COUNT_VAL_RESET   = 10'h000;

    // Timing figures
    localparam real         CORE_CLK_MHZ         = 40.0;
    localparam int unsigned SYNC_ALIGN_MAX_CYCLES = 16;

endpackage : lmp_pkg

// ### design/lmp_count_store.sv
// Per-channel turn-on and turn-off counts: staging and active registers.
// Assumes hit strobes come from the period counter comparison in the core.
`timescale 1ns/1ps
`default_nettype none

module lmp_count_store (
    input  wire logic                                      core_clk_i,
    input  wire logic                                      rstn_i,
    input  wire logic                                      wr_i,
    input  wire logic [lmp_pkg::CH_IDX_W-1:0]              wr_chan_i,
    input  wire logic                                      wr_sel_off_i,
    input  wire logic [lmp_pkg::CNT_W-1:0]                 wr_data_i,
    input  wire logic [lmp_pkg::NUM_CH-1:0]                on_hit_i,
    input  wire logic [lmp_pkg::NUM_CH-1:0]                off_hit_i,
    output logic      [lmp_pkg::NUM_CH*lmp_pkg::CNT_W-1:0] act_on_o,
    output logic      [lmp_pkg::NUM_CH*lmp_pkg::CNT_W-1:0] act_off_o
);

    genvar i;
    generate
        for (i = 0; i < lmp_pkg::NUM_CH; i++) begin : g_ch
            localparam logic [3:0] CH_ID = 4'(i);
            logic [lmp_pkg::CNT_W-1:0] stage_on_q;
            logic [lmp_pkg::CNT_W-1:0] stage_off_q;
            logic [lmp_pkg::CNT_W-1:0] stage_on_d;
            logic [lmp_pkg::CNT_W-1:0] stage_off_d;
            logic [lmp_pkg::CNT_W-1:0] act_on_q;
            logic [lmp_pkg::CNT_W-1:0] act_off_q;
            wire                       wr_on  = wr_i & (wr_chan_i == CH_ID) & ~wr_sel_off_i;
            wire                       wr_off = wr_i & (wr_chan_i == CH_ID) & wr_sel_off_i;

            assign stage_on_d  = wr_on  ? wr_data_i : stage_on_q;
            assign stage_off_d = wr_off ? wr_data_i : stage_off_q;

            always_ff @(posedge core_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    stage_on_q  <= lmp_pkg::COUNT_VAL_RESET;
                    stage_off_q <= lmp_pkg::COUNT_VAL_RESET;
                    act_on_q    <= lmp_pkg::COUNT_VAL_RESET;
                    act_off_q   <= lmp_pkg::COUNT_VAL_RESET;
                end else begin
                    stage_on_q  <= stage_on_d;
                    stage_off_q <= stage_off_d;
                    if (off_hit_i[i]) begin
                        act_on_q <= stage_on_d;
                    end
                    if (on_hit_i[i]) begin
                        act_off_q <= stage_off_d;
                    end
                end
            end

            assign act_on_o[i*lmp_pkg::CNT_W +: lmp_pkg::CNT_W]  = act_on_q;
            assign act_off_o[i*lmp_pkg::CNT_W +: lmp_pkg::CNT_W] = act_off_q;
        end
    endgenerate

endmodule : lmp_count_store

`default_nettype wire

// ### bench/lmp_checker.sv
// Port checker for the LED PWM dimming core.
// Assumes binding onto lmp_dimming_core, one clock, async low reset.
`timescale 1ns/1ps
`default_nettype none
module lmp_checker (
    input wire logic        core_clk_i,
    input wire logic        rstn_i,
    input wire logic        cfg_wr_i,
    input wire logic [7:0]  pwm_clock_divider_setting_i,
    input wire logic        sync_master_select_i,
    input wire logic        sync_cmd_i,
    input wire logic        sync_i,
    input wire logic [11:0] channel_compare_enable_i,
    input wire logic        sync_o,
    input wire logic        sync_oe_o,
    input wire logic [11:0] bypass_on_o,
    input wire logic [9:0]  pwm_period_counter_o,
    input wire logic [7:0]  divider_setting_o,
    input wire logic        sync_master_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_step;
        $changed(pwm_period_counter_o) && pwm_period_counter_o != 10'h000
            |-> pwm_period_counter_o == $past(pwm_period_counter_o) + 10'h001;
    endproperty
    a_step: assert property (p_step) else $error("counter skipped");
    property p_tick;
        $changed(pwm_period_counter_o) && pwm_period_counter_o > 10'h001
            && divider_setting_o == 8'h04
            |-> $past(pwm_period_counter_o, 16) == pwm_period_counter_o - 10'h001;
    endproperty
    a_tick: assert property (p_tick) else $error("tick not every 16");
    property p_cfg;
        cfg_wr_i |=> divider_setting_o == $past(pwm_clock_divider_setting_i)
            && sync_oe_o == $past(sync_master_select_i);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config not loaded");
    property p_rst;
        $rose(rstn_i) |-> pwm_period_counter_o == 10'h000 && bypass_on_o == 12'hFFF
            && divider_setting_o == 8'h04 && !sync_oe_o;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_en;
        ((bypass_on_o ^ $past(bypass_on_o)) & ~channel_compare_enable_i
            & ~$past(channel_compare_enable_i)) == 12'h000;
    endproperty
    a_en: assert property (p_en) else $error("disabled channel moved");
    property p_mrise;
        sync_master_o && $changed(pwm_period_counter_o) && pwm_period_counter_o == 10'h000
            && $past(pwm_period_counter_o) == 10'h3FF |=> sync_o;
    endproperty
    a_mrise: assert property (p_mrise) else $error("no sync pulse at wrap");
    property p_mlow;
        sync_master_o && pwm_period_counter_o > 10'h201 |-> !sync_o;
    endproperty
    a_mlow: assert property (p_mlow) else $error("sync pulse too long");
    property p_fol;
        ($rose(sync_i) && !sync_master_o) ##1 sync_i
            |-> ##[1:4] pwm_period_counter_o == 10'h000;
    endproperty
    a_fol: assert property (p_fol) else $error("sync edge ignored");
    property p_cmd;
        sync_cmd_i |=> pwm_period_counter_o == 10'h000;
    endproperty
    a_cmd: assert property (p_cmd) else $error("sync command ignored");
endmodule : lmp_checker
bind lmp_dimming_core lmp_checker u_chk (.core_clk_i, .rstn_i, .cfg_wr_i,
    .pwm_clock_divider_setting_i, .sync_master_select_i, .sync_cmd_i, .sync_i,
    .channel_compare_enable_i, .sync_o, .sync_oe_o, .bypass_on_o,
    .pwm_period_counter_o, .divider_setting_o, .sync_master_o);
`default_nettype wire

// ### bench/lmp_sync_peer.sv
// Peer on the shared sync line that pulses it in follower tests.
// Assumes a pull-down on the line and the same clock as the core.
`timescale 1ns/1ps
`default_nettype none
module lmp_sync_peer (
    input  wire logic core_clk_i,
    input  wire logic pulse_i,
    input  wire logic dut_oe_i,
    input  wire logic dut_sync_i,
    output logic      sync_line_o
);
    logic [2:0] hold_q = 3'h0;
    always_ff @(posedge core_clk_i) begin
        if (pulse_i && !dut_oe_i) begin
            hold_q <= 3'h4;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end
    end
    // Device drives when master, else peer, else pull-down
    assign sync_line_o = dut_oe_i ? dut_sync_i : (hold_q != 3'h0);
endmodule : lmp_sync_peer
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the LED PWM dimming core.
// Assumes the core, the checker bind and the sync peer compile first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        core_clk_i = 1'b0;
    logic        rstn_i     = 1'b0;
    logic        cnt_wr_i   = 1'b0;
    logic [3:0]  chan       = 4'h0;
    logic        sel_off    = 1'b0;
    logic [9:0]  wdata      = 10'h000;
    logic        cfg_wr_i   = 1'b0;
    logic [7:0]  div        = 8'h04;
    logic        msel       = 1'b0;
    logic        sync_cmd_i = 1'b0;
    logic        pulse      = 1'b0;
    wire         sync_line;
    wire         sync_o;
    wire         sync_oe_o;
    wire  [11:0] bypass;
    wire  [9:0]  cnt;
    wire  [7:0]  div_o;
    wire         sync_mst;
    logic [11:0] en_mask    = 12'hBFF;
    int          bad_count = 0;
    int          samples_checked = 0;
    logic [21:0] rows [5] = '{{10'h000, 12'hFFE}, {10'h032, 12'hFF0},
        {10'h078, 12'hF03}, {10'h0F0, 12'hDFF}, {10'h1F4, 12'hFFF}};
    always #12.5 core_clk_i = ~core_clk_i;
    lmp_dimming_core uut (.core_clk_i, .rstn_i, .cnt_wr_i, .cnt_wr_chan_i(chan),
        .cnt_wr_sel_off_i(sel_off), .cnt_wr_data_i(wdata),
        .channel_compare_enable_i(en_mask), .cfg_wr_i, .pwm_clock_divider_setting_i(div),
        .sync_master_select_i(msel), .sync_cmd_i, .sync_i(sync_line), .sync_o,
        .sync_oe_o, .bypass_on_o(bypass), .pwm_period_counter_o(cnt),
        .divider_setting_o(div_o), .sync_master_o(sync_mst));
    lmp_sync_peer u_peer (.core_clk_i, .pulse_i(pulse), .dut_oe_i(sync_oe_o),
        .dut_sync_i(sync_o), .sync_line_o(sync_line));
    task automatic chk(input logic [11:0] exp, input logic [11:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : cyc
    task automatic wait_cnt(input logic [9:0] v);
        for (int k = 0; k < 20000 && cnt !== v; k++) begin
            cyc(1);
        end
        if (cnt !== v) begin
            chk({2'h0, v}, {2'h0, cnt});
        end
    endtask : wait_cnt
    task automatic pt(input logic [9:0] v, input logic e);
        wait_cnt(v);
        cyc(3);
        chk({11'h000, e}, {11'h000, bypass[0]});
    endtask : pt
    task automatic cfg(input logic [7:0] d, input logic m);
        div = d;
        msel = m;
        cfg_wr_i = 1'b1;
        cyc(1);
        cfg_wr_i = 1'b0;
        cyc(1);
        chk({4'h0, d}, {4'h0, div_o});
        chk({11'h000, m}, {11'h000, sync_oe_o});
        chk({11'h000, m}, {11'h000, sync_mst});
    endtask : cfg
    task automatic tick_gap(input logic [11:0] exp);
        logic [9:0] v;
        int         n;
        n = 0;
        v = cnt;
        while (cnt === v) begin
            cyc(1);
        end
        v = cnt;
        while (cnt === v && n < 300) begin
            n++;
            cyc(1);
        end
        chk(exp, 12'(n));
    endtask : tick_gap
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        cyc(80000);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        cyc(3);
        rstn_i = 1'b1;
        cyc(40);
        chk(12'h002, {2'h0, cnt});
        cfg(8'h03, 1'b0);
        tick_gap(12'h008);
        cnt_wr_i = 1'b1;
        for (int i = 0; i < 24; i++) begin
            chan = 4'(i / 2);
            sel_off = i[0];
            wdata = (i / 2 == 11) ? 10'h1F4 : 10'((i / 2) * 16 + (i % 2) * 100);
            cyc(1);
        end
        cnt_wr_i = 1'b0;
        wait_cnt(10'h3FF);
        wait_cnt(10'h000);
        wait_cnt(10'h3FF);
        foreach (rows[r]) begin
            wait_cnt(rows[r][21:12]);
            cyc(3);
            chk(rows[r][11:0], bypass);
        end
        $display("test table done");
        wait_cnt(10'h032);
        chan = 4'h0;
        sel_off = 1'b1;
        wdata = 10'h01E;
        cnt_wr_i = 1'b1;
        cyc(1);
        cnt_wr_i = 1'b0;
        pt(10'h03C, 1'b0);
        pt(10'h06E, 1'b1);
        pt(10'h014, 1'b0);
        pt(10'h028, 1'b1);
        $display("test staging done");
        en_mask = 12'hBFD;
        wait_cnt(10'h078);
        cyc(3);
        chk(12'h000, {11'h000, bypass[1]});
        en_mask = 12'hBFF;
        $display("test enable done");
        wait_cnt(10'h080);
        sync_cmd_i = 1'b1;
        cyc(1);
        sync_cmd_i = 1'b0;
        chk(12'h000, {2'h0, cnt});
        wait_cnt(10'h080);
        pulse = 1'b1;
        cyc(1);
        pulse = 1'b0;
        cyc(5);
        chk(12'h000, {2'h0, cnt});
        $display("test sync done");
        cfg(8'h00, 1'b1);
        wait_cnt(10'h3FF);
        wait_cnt(10'h100);
        chk(12'h001, {11'h000, sync_o});
        wait_cnt(10'h300);
        chk(12'h000, {11'h000, sync_o});
        cfg(8'h0B, 1'b1);
        tick_gap(12'h010);
        $display("test master done");
        rstn_i = 1'b0;
        cyc(2);
        chk(12'hFFF, bypass);
        chk(12'h000, {2'h0, cnt});
        rstn_i = 1'b1;
        cyc(2);
        chk(12'h004, {4'h0, div_o});
        $display("test reset done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
